// ==== hdl/ccr_pkg.sv ====
package ccr_pkg;

    // Serial bus slave address and register indices.
    localparam logic [6:0] CCR_SLAVE_ADDR = 7'h3B;
    localparam logic [7:0] CCR_CONV_OFFS = 8'h01;
    localparam logic [7:0] CCR_CHG_OFFS = 8'h02;
    localparam logic [7:0] CCR_CONV_RESET = 8'h1A;
    localparam logic [7:0] CCR_CHG_RESET = 8'hA2;
    localparam logic [7:0] CCR_READ_NONE = 8'h00;

    // Converter control field positions.
    localparam int CCR_PULSE_OFF_BIT = 7;
    localparam int CCR_KICK_BIT = 6;
    localparam int CCR_BOOST_BIT = 5;
    localparam int CCR_ALLOW_BIT = 4;
    localparam int CCR_FLOOR_HI = 3;
    localparam int CCR_FLOOR_LO = 1;
    localparam int CCR_LOWBAT_BIT = 0;

    // Charge current control field positions.
    localparam int CCR_CAP_BIT = 7;
    localparam int CCR_FULLON_BIT = 6;
    localparam int CCR_FCC_HI = 5;

    // Fields that watchdog expiry also restores.
    localparam logic [7:0] CCR_CONV_WD_MASK = 8'h70;
    localparam logic [7:0] CCR_CHG_WD_MASK = 8'hBF;

    // Analog setting values in millivolts and milliamps.
    localparam logic [11:0] CCR_FCC_STEP_MA = 12'h03C;
    localparam logic [11:0] CCR_CAP_LOW_MA = 12'h4B0;
    localparam logic [11:0] CCR_CAP_HIGH_MA = 12'h7D0;
    localparam logic [11:0] CCR_LOWBAT_FALL_MV = 12'hBB8;
    localparam logic [11:0] CCR_LOWBAT_RISE_MV = 12'hC80;
    localparam logic [4:0] CCR_ILIM_700MA_CODE = 5'h06;

    // System floor voltage in millivolts for each floor code.
    localparam logic [11:0] CCR_FLOOR_MV [8] = '{
        12'hA28, 12'hAF0, 12'hBB8, 12'hC80, 12'hD48, 12'hDAC, 12'hE10, 12'hE74
    };

    // Watchdog periods in seconds, selected by the period code.
    localparam logic [1:0] CCR_WD_OFF = 2'h0;
    localparam logic [7:0] CCR_WD_40S = 8'h28;
    localparam logic [7:0] CCR_WD_80S = 8'h50;
    localparam logic [7:0] CCR_WD_160S = 8'hA0;
    localparam int CCR_CLK_HZ = 100000000;
    localparam int CCR_SECOND_CYCLES = CCR_CLK_HZ;

    localparam logic [3:0] CCR_BIT_LAST = 4'h8;

    typedef enum logic [6:0] {
        CCR_IDLE = 7'b0000001,
        CCR_ADDR = 7'b0000010,
        CCR_REGA = 7'b0000100,
        CCR_WDAT = 7'b0001000,
        CCR_SACK = 7'b0010000,
        CCR_RDAT = 7'b0100000,
        CCR_MACK = 7'b1000000
    } ccr_state_t;

endpackage

// ==== hdl/ccr_top.sv ====
`timescale 1ns/10ps
module ccr_top
    import ccr_pkg::*;
#(
    parameter int SECOND_CYCLES = CCR_SECOND_CYCLES,
    parameter logic [11:0] LOWBAT_ALT_FALL_MV = 12'hC1C,
    parameter logic [11:0] LOWBAT_ALT_RISE_MV = 12'hD1C
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Two-wire serial bus.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Device inputs.
    input wire logic reg_defaults_reset_i,
    input wire logic charge_enable_pin_low_n_i,
    input wire logic [1:0] watchdog_period_i,
    input wire logic [4:0] input_current_limit_i,
    // Register contents.
    output logic [7:0] converter_control_o,
    output logic [7:0] charge_current_control_o,
    // Decoded controls.
    output logic light_load_pulse_mode_off_o,
    output logic boost_mode_o,
    output logic charge_on_o,
    output logic [11:0] system_floor_mv_o,
    output logic [11:0] lowbat_fall_mv_o,
    output logic [11:0] lowbat_rise_mv_o,
    output logic [11:0] boost_cap_ma_o,
    output logic input_switch_full_on_o,
    output logic [11:0] charge_current_ma_o,
    output logic watchdog_expired_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog.

    logic [31:0] tick_q, tick_d;
    logic [7:0] sec_q, sec_d;
    logic [7:0] wd_limit;
    logic wd_expire;
    logic [7:0] conv_q, conv_d, chg_q, chg_d;

    always_comb begin
        case (watchdog_period_i)
            2'h1: wd_limit = CCR_WD_40S;
            2'h2: wd_limit = CCR_WD_80S;
            default: wd_limit = CCR_WD_160S;
        endcase
        tick_d = tick_q + 32'h00000001;
        sec_d = sec_q;
        wd_expire = 1'b0;
        if (tick_q == 32'(SECOND_CYCLES - 1)) begin
            tick_d = 32'h00000000;
            sec_d = sec_q + 8'h01;
            if (sec_d == wd_limit) begin
                wd_expire = 1'b1;
            end
        end
        if (watchdog_period_i == CCR_WD_OFF || conv_q[CCR_KICK_BIT] || wd_expire
                || reg_defaults_reset_i) begin
            tick_d = 32'h00000000;
            sec_d = 8'h00;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tick_q <= 32'h00000000;
            sec_q <= 8'h00;
        end else begin
            tick_q <= tick_d;
            sec_q <= sec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial slave and register file.

    ccr_state_t state_q, state_d, after_q, after_d;
    logic scl_q, sda_q, oe_q, oe_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sr_q, sr_d, tx_q, tx_d, ptr_q, ptr_d;
    logic nack_q, nack_d;
    logic start_ev, stop_ev, scl_rise, scl_fall;
    logic [7:0] rd_data;

    assign start_ev = scl_i && scl_q && sda_q && !sda_i;
    assign stop_ev = scl_i && scl_q && !sda_q && sda_i;
    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;

    always_comb begin
        case (ptr_q)
            CCR_CONV_OFFS: rd_data = conv_q;
            CCR_CHG_OFFS: rd_data = chg_q;
            default: rd_data = CCR_READ_NONE;
        endcase
    end

    always_comb begin
        state_d = state_q;
        after_d = after_q;
        oe_d = oe_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        nack_d = nack_q;
        conv_d = conv_q;
        chg_d = chg_q;
        conv_d[CCR_KICK_BIT] = 1'b0;
        if (wd_expire) begin
            conv_d = (conv_d & ~CCR_CONV_WD_MASK) | (CCR_CONV_RESET & CCR_CONV_WD_MASK);
            chg_d = (chg_q & ~CCR_CHG_WD_MASK) | (CCR_CHG_RESET & CCR_CHG_WD_MASK);
        end
        if (start_ev) begin
            state_d = CCR_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_ev) begin
            state_d = CCR_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            if (state_q == CCR_MACK) begin
                nack_d = sda_i;
            end else if (state_q == CCR_ADDR || state_q == CCR_REGA || state_q == CCR_WDAT) begin
                sr_d = {sr_q[6:0], sda_i};
                cnt_d = cnt_q + 4'h1;
            end
        end else if (scl_fall) begin
            case (state_q)
                CCR_ADDR, CCR_REGA, CCR_WDAT: begin
                    if (cnt_q == CCR_BIT_LAST) begin
                        cnt_d = 4'h0;
                        oe_d = 1'b1;
                        state_d = CCR_SACK;
                        after_d = CCR_WDAT;
                        if (state_q == CCR_ADDR) begin
                            if (sr_q[7:1] != CCR_SLAVE_ADDR) begin
                                oe_d = 1'b0;
                                state_d = CCR_IDLE;
                            end
                            after_d = sr_q[0] ? CCR_RDAT : CCR_REGA;
                        end else if (state_q == CCR_REGA) begin
                            ptr_d = sr_q;
                        end else begin
                            if (ptr_q == CCR_CONV_OFFS) begin
                                conv_d = sr_q;
                            end
                            if (ptr_q == CCR_CHG_OFFS) begin
                                chg_d = sr_q;
                            end
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                CCR_SACK, CCR_MACK: begin
                    oe_d = 1'b0;
                    if (state_q == CCR_MACK && nack_q) begin
                        state_d = CCR_IDLE;
                    end else if (state_q == CCR_MACK || after_q == CCR_RDAT) begin
                        tx_d = rd_data;
                        oe_d = !rd_data[7];
                        ptr_d = ptr_q + 8'h01;
                        cnt_d = 4'h1;
                        state_d = CCR_RDAT;
                    end else begin
                        state_d = after_q;
                    end
                end
                CCR_RDAT: begin
                    if (cnt_q == CCR_BIT_LAST) begin
                        oe_d = 1'b0;
                        state_d = CCR_MACK;
                    end else begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = !tx_q[6];
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
        if (reg_defaults_reset_i) begin
            conv_d = CCR_CONV_RESET;
            chg_d = CCR_CHG_RESET;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= CCR_IDLE;
            after_q <= CCR_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            nack_q <= 1'b1;
            conv_q <= CCR_CONV_RESET;
            chg_q <= CCR_CHG_RESET;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            scl_q <= scl_i;
            sda_q <= sda_i;
            oe_q <= oe_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            nack_q <= nack_d;
            conv_q <= conv_d;
            chg_q <= chg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded outputs.

    logic [11:0] floor_mv;

    always_comb begin
        floor_mv = CCR_FLOOR_MV[conv_q[CCR_FLOOR_HI:CCR_FLOOR_LO]];
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            converter_control_o <= CCR_CONV_RESET;
            charge_current_control_o <= CCR_CHG_RESET;
            light_load_pulse_mode_off_o <= 1'b0;
            boost_mode_o <= 1'b0;
            charge_on_o <= 1'b0;
            system_floor_mv_o <= 12'h000;
            lowbat_fall_mv_o <= CCR_LOWBAT_FALL_MV;
            lowbat_rise_mv_o <= CCR_LOWBAT_RISE_MV;
            boost_cap_ma_o <= CCR_CAP_HIGH_MA;
            input_switch_full_on_o <= 1'b0;
            charge_current_ma_o <= 12'h000;
            watchdog_expired_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= oe_q;
            converter_control_o <= conv_q;
            charge_current_control_o <= chg_q;
            light_load_pulse_mode_off_o <= conv_q[CCR_PULSE_OFF_BIT];
            boost_mode_o <= conv_q[CCR_BOOST_BIT];
            charge_on_o <= conv_q[CCR_ALLOW_BIT] && !charge_enable_pin_low_n_i
                && !conv_q[CCR_BOOST_BIT] && (chg_q[CCR_FCC_HI:0] != 6'h00);
            system_floor_mv_o <= floor_mv;
            lowbat_fall_mv_o <= conv_q[CCR_LOWBAT_BIT] ? LOWBAT_ALT_FALL_MV
                : CCR_LOWBAT_FALL_MV;
            lowbat_rise_mv_o <= conv_q[CCR_LOWBAT_BIT] ? LOWBAT_ALT_RISE_MV
                : CCR_LOWBAT_RISE_MV;
            boost_cap_ma_o <= chg_q[CCR_CAP_BIT] ? CCR_CAP_HIGH_MA : CCR_CAP_LOW_MA;
            input_switch_full_on_o <= conv_q[CCR_BOOST_BIT]
                || chg_q[CCR_FULLON_BIT] || (input_current_limit_i >= CCR_ILIM_700MA_CODE);
            charge_current_ma_o <= 12'(CCR_FCC_STEP_MA * {6'h00, chg_q[CCR_FCC_HI:0]});
            watchdog_expired_o <= wd_expire;
        end
    end

endmodule // ccr_top

// ==== sim/ccr_assertions.sv ====
`timescale 1ns/10ps
module ccr_checker
    import ccr_pkg::*;
#(
    parameter logic [11:0] LOWBAT_ALT_FALL_MV = 12'hC1C,
    parameter logic [11:0] LOWBAT_ALT_RISE_MV = 12'hD1C
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Device inputs.
    input wire logic reg_defaults_reset_i,
    input wire logic charge_enable_pin_low_n_i,
    input wire logic [4:0] input_current_limit_i,
    // Register contents and decoded controls.
    input wire logic [7:0] converter_control_o,
    input wire logic [7:0] charge_current_control_o,
    input wire logic light_load_pulse_mode_off_o,
    input wire logic boost_mode_o,
    input wire logic charge_on_o,
    input wire logic [11:0] system_floor_mv_o,
    input wire logic [11:0] lowbat_fall_mv_o,
    input wire logic [11:0] lowbat_rise_mv_o,
    input wire logic [11:0] boost_cap_ma_o,
    input wire logic input_switch_full_on_o,
    input wire logic [11:0] charge_current_ma_o,
    input wire logic watchdog_expired_o
);
    logic [15:0] rg;
    logic [15:0] r1_q;
    logic [15:0] r2_q;
    logic [5:0] in1_q;
    logic [1:0] age_q;
    logic stb;
    assign rg = {converter_control_o, charge_current_control_o};
    // Decoded outputs are only judged once registers and inputs have settled.
    always_ff @(posedge mclk_i) begin
        r1_q <= rg;
        r2_q <= r1_q;
        in1_q <= {charge_enable_pin_low_n_i, input_current_limit_i};
        age_q <= rst_i ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
    end
    assign stb = (age_q == 2'h3) && (rg == r1_q) && (r1_q == r2_q)
        && (in1_q == {charge_enable_pin_low_n_i, input_current_limit_i});
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    pulse_off_a: assert property (stb |-> light_load_pulse_mode_off_o == rg[15])
        else $error("pulse mode flag differs from register");
    kick_clear_a: assert property (converter_control_o[6] |=> !converter_control_o[6])
        else $error("kick bit did not clear");
    boost_mode_a: assert property (stb |-> boost_mode_o == rg[13])
        else $error("boost flag differs from register");
    charge_on_a: assert property (stb |-> charge_on_o == (rg[12]
        && !charge_enable_pin_low_n_i && !rg[13] && rg[5:0] != 6'h00))
        else $error("charge enable wrong");
    floor_a: assert property (stb |-> system_floor_mv_o == (rg[11:9] < 3'h5
        ? 12'hA28 + 12'h0C8 * rg[11:9] : 12'hDAC + 12'h064 * (rg[11:9] - 3'h5)))
        else $error("floor voltage wrong");
    lowbat_a: assert property (stb |-> {lowbat_fall_mv_o, lowbat_rise_mv_o} == (rg[8]
        ? {LOWBAT_ALT_FALL_MV, LOWBAT_ALT_RISE_MV} : {12'hBB8, 12'hC80}))
        else $error("low battery thresholds wrong");
    boost_cap_a: assert property (stb |-> boost_cap_ma_o == (rg[7] ? 12'h7D0 : 12'h4B0))
        else $error("boost current cap wrong");
    switch_mode_a: assert property (stb |-> input_switch_full_on_o
        == (rg[13] || rg[6] || input_current_limit_i >= 5'h06))
        else $error("input switch mode wrong");
    fcc_value_a: assert property (stb |-> charge_current_ma_o == 12'h03C * rg[5:0])
        else $error("charge current wrong");
    zero_code_a: assert property (stb && rg[5:0] == 6'h00 |-> !charge_on_o)
        else $error("charging with zero current code");
    wd_restore_a: assert property (watchdog_expired_o |-> ##[0:1]
        ({rg[14:12], rg[7], rg[5:0]} == {3'h1, 1'h1, 6'h22}))
        else $error("watchdog expiry did not restore fields");
    defaults_a: assert property (reg_defaults_reset_i [*2] |=> rg == 16'h1AA2)
        else $error("defaults reset did not restore registers");
endmodule // ccr_checker

bind ccr_top ccr_checker #(
    .LOWBAT_ALT_FALL_MV(LOWBAT_ALT_FALL_MV),
    .LOWBAT_ALT_RISE_MV(LOWBAT_ALT_RISE_MV)
) u_chk (
    .mclk_i, .rst_i, .reg_defaults_reset_i, .charge_enable_pin_low_n_i,
    .input_current_limit_i, .converter_control_o, .charge_current_control_o,
    .light_load_pulse_mode_off_o, .boost_mode_o, .charge_on_o, .system_floor_mv_o,
    .lowbat_fall_mv_o, .lowbat_rise_mv_o, .boost_cap_ma_o, .input_switch_full_on_o,
    .charge_current_ma_o, .watchdog_expired_o
);

// ==== sim/ccr_host.sv ====
`timescale 1ns/10ps
module ccr_host (
    // Clock and serial bus.
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    localparam int HALF = 5;
    initial begin
        scl_o = 1'h1;
        sda_pull_o = 1'h0;
    end
    // Samples the wire at the end of a phase, then moves both lines.
    task automatic step(input logic c, input logic p, output logic r);
        repeat (HALF) @(posedge mclk_i);
        #1;
        r = sda_i;
        scl_o = c;
        sda_pull_o = p;
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(1'h0, !b, r);
        step(1'h1, !b, r);
        step(1'h0, !b, r);
    endtask
    // Serves as both first and repeated start.
    task automatic start();
        logic r;
        step(1'h0, 1'h0, r);
        step(1'h1, 1'h0, r);
        step(1'h1, 1'h1, r);
        step(1'h0, 1'h1, r);
    endtask
    task automatic stop();
        logic r;
        step(1'h0, 1'h1, r);
        step(1'h1, 1'h1, r);
        step(1'h1, 1'h0, r);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(a, k);
    endtask
endmodule // ccr_host

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb
    import ccr_pkg::*;
;
    logic mclk_i, rst_i, scl, pull, sda, sda_o, sda_oe, def, pin_n, on, fullon;
    logic [1:0] wdp;
    logic [4:0] lim;
    logic [7:0] conv, chg;
    logic [11:0] floor_mv, fcc_ma;
    logic wd_exp;
    logic [15:0] m, d, v;
    int err_count, samples_checked;
    int fl[8] = '{2600, 2800, 3000, 3200, 3400, 3500, 3600, 3700};
    localparam int SEC_CYC = 10;
    assign sda = !(pull || (sda_oe && !sda_o));
    ccr_top #(.SECOND_CYCLES(SEC_CYC)) u_dut (.mclk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o,
        .sda_oe_o(sda_oe), .reg_defaults_reset_i(def), .charge_enable_pin_low_n_i(pin_n),
        .watchdog_period_i(wdp), .input_current_limit_i(lim), .converter_control_o(conv),
        .charge_current_control_o(chg), .light_load_pulse_mode_off_o(), .boost_mode_o(),
        .charge_on_o(on), .system_floor_mv_o(floor_mv), .lowbat_fall_mv_o(),
        .lowbat_rise_mv_o(), .boost_cap_ma_o(), .input_switch_full_on_o(fullon),
        .charge_current_ma_o(fcc_ma), .watchdog_expired_o(wd_exp));
    ccr_host u_host (.mclk_i, .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] x, input logic nak);
        logic [7:0] q;
        logic k;
        u_host.start();
        u_host.xfer({a, 1'h0}, 1'h1, q, k);
        chk("address ack", {15'h0, nak}, {15'h0, k});
        u_host.xfer(CCR_CONV_OFFS, 1'h1, q, k);
        u_host.xfer(x[15:8], 1'h1, q, k);
        u_host.xfer(x[7:0], 1'h1, q, k);
        chk("data ack", {15'h0, nak}, {15'h0, k});
        u_host.stop();
        repeat (4) @(posedge mclk_i);
        #1;
    endtask
    task automatic rd_chk();
        logic [7:0] q;
        logic k;
        u_host.start();
        u_host.xfer({CCR_SLAVE_ADDR, 1'h0}, 1'h1, q, k);
        u_host.xfer(CCR_CONV_OFFS, 1'h1, q, k);
        u_host.start();
        u_host.xfer({CCR_SLAVE_ADDR, 1'h1}, 1'h1, q, k);
        u_host.xfer(8'hFF, 1'h0, v[15:8], k);
        u_host.xfer(8'hFF, 1'h1, v[7:0], k);
        u_host.stop();
        chk("bus read", m, v);
        chk("register outputs", m, {conv, chg});
    endtask
    // Starts the watchdog from a cleared count and times its expiry.
    task automatic wd_run(input logic [1:0] p, input int secs);
        int n;
        n = 0;
        wdp = p;
        while (n < 2000 && wd_exp !== 1'h1) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk("expiry cycles", 16'(secs * SEC_CYC), 16'(n));
        wdp = 2'h0;
        @(posedge mclk_i);
        #1;
    endtask
    initial begin
        {rst_i, def, pin_n, wdp, lim} = {1'h1, 1'h0, 1'h0, 2'h0, 5'h00};
        void'($urandom(32'hE3FFFDD6));
        repeat (8) @(posedge mclk_i);
        #1;
        rst_i = 1'h0;
        m = 16'h1AA2;
        repeat (3) @(posedge mclk_i);
        rd_chk();
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            d[11:9] = 3'(i);
            pin_n = 1'($urandom);
            lim = 5'($urandom);
            if (i == 0) begin
                {d[13:12], d[5:0], pin_n} = {2'h1, 6'h00, 1'h0};
            end
            wr(CCR_SLAVE_ADDR, d, 1'h0);
            m = d & 16'hBFFF;
            chk("floor", 16'(fl[i]), {4'h0, floor_mv});
            chk("current", 16'(60 * m[5:0]), {4'h0, fcc_ma});
            chk("charge", {15'h0, m[12] && !pin_n && !m[13] && m[5:0] != 0}, {15'h0, on});
            chk("switch", {15'h0, m[13] || m[6] || lim >= 5'h06}, {15'h0, fullon});
            rd_chk();
        end
        wr(7'h3C, 16'h0000, 1'h1);
        rd_chk();
        wdp = 2'h2;
        wr(CCR_SLAVE_ADDR, 16'hFF7F, 1'h0);
        m = 16'hBF7F;
        for (int n = 0; n < 1000 && wd_exp !== 1'h1; n++) begin
            @(posedge mclk_i);
            #1;
        end
        chk("expiry seen", 16'h1, {15'h0, wd_exp});
        wdp = 2'h0;
        repeat (2) @(posedge mclk_i);
        #1;
        m = (m & 16'h8F40) | 16'h10A2;
        rd_chk();
        def = 1'h1;
        repeat (3) @(posedge mclk_i);
        #1;
        def = 1'h0;
        m = 16'h1AA2;
        repeat (3) @(posedge mclk_i);
        rd_chk();
        wd_run(2'h1, 40);
        wd_run(2'h3, 160);
        final_report();
    end
endmodule // tb
